// [verilog/ltm_timer.sv]
/*
 * Lifetime timer: 48-bit up counter or 16-bit up/down counter with
 * reload, prescaler, clock select, event capture and interrupt.
 * Assumes an Avalon-MM master on sys_clk_i, slow clock pins from
 * outside the domain and interrupt sources on the same clock.
 */
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module ltm_timer
	import ltm_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        clk_en_i,
	input  wire logic [31:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        lp_osc_i,
	input  wire logic        xtal_i,
	input  wire logic        prec_osc_i,
	input  wire logic [17:0] irq_src_i,
	output logic             irq_o
);

	logic [31:0] ctrl_reg;     // Control register
	logic [15:0] load_reg;     // Reload value
	logic [15:0] capt_reg;     // Captured count
	logic [47:0] cnt_reg;      // Counter
	logic [14:0] pre_reg;      // Prescaler count
	logic        src_prev_reg; // Selected source last cycle
	logic [31:0] rdata_next;   // Read mux
	logic [31:0] wmask;        // Byte lane mask
	logic [31:0] ctrl_next;    // Merged control write
	logic [2:0]  slow_rise;    // Slow clock edges
	logic        src_tick;     // Selected clock edge
	logic [14:0] pre_max;      // Prescaler terminal count
	logic        cnt_tick;     // Counter step
	logic        wr_acc;       // Write accepted this cycle
	logic        wide;         // 48-bit mode
	logic        up;           // Count up in 16-bit mode
	logic        wrap;         // 16-bit wrap this cycle
	logic        sel_src;      // Selected interrupt source
	logic        capt_hit;     // Capture event
	logic        clr_hit;      // Interrupt clear write

	// Slow sources, one synchroniser each
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			ltm_edge_sync u_sync (
				.sys_clk_i (sys_clk_i),
				.sys_rst_i (sys_rst_i),
				.clk_en_i  (clk_en_i),
				.pin_i     (gi == 0 ? lp_osc_i :
				            gi == 1 ? xtal_i : prec_osc_i),
				.rise_o    (slow_rise[gi])
			);
		end
	endgenerate

	// Mode bits
	assign wide = ctrl_reg[LTM_CTL_WIDE];
	assign up   = ctrl_reg[LTM_CTL_UP];

	// Clock source select
	always_comb begin
		case (ctrl_reg[LTM_CTL_CLK_LSB +: 2])
			LTM_CLK_CORE: src_tick = 1'b1;
			LTM_CLK_LPO:  src_tick = slow_rise[0];
			LTM_CLK_XTAL: src_tick = slow_rise[1];
			LTM_CLK_PREC: src_tick = slow_rise[2];
			default:      src_tick = 1'b0;
		endcase
	end

	// Prescaler ratio; undefined codes divide by one
	always_comb begin
		case (ctrl_reg[LTM_CTL_PRE_LSB +: 4])
			LTM_PRE_DIV16:    pre_max = LTM_PRE_MAX16;
			LTM_PRE_DIV256:   pre_max = LTM_PRE_MAX256;
			LTM_PRE_DIV32768: pre_max = LTM_PRE_MAX32768;
			default:          pre_max = LTM_PRE_MAX1;
		endcase
	end

	// Counter step when enabled, source edge and prescaler terminal
	assign cnt_tick = clk_en_i && ctrl_reg[LTM_CTL_ENABLE] && src_tick &&
	                  (pre_reg >= pre_max);

	// 16-bit wrap: overflow going up, underflow going down
	assign wrap = cnt_tick && !wide &&
	              (up ? cnt_reg[15:0] == LTM_N_MAX
	                  : cnt_reg[15:0] == LTM_N_MIN);

	// Bus strobes
	assign wr_acc  = clk_en_i && avs_write_i && !avs_waitrequest_o;
	assign clr_hit = wr_acc && avs_address_i == LTM_ADDR_CLEAR;
	assign wmask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
	                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign ctrl_next = ((ctrl_reg & ~wmask) | (avs_writedata_i & wmask))
	                   & LTM_CTRL_MASK;

	// Capture source: out-of-range numbers never fire
	assign sel_src = (ctrl_reg[LTM_CTL_SRC_LSB +: 5] <= LTM_SRC_LAST) &&
	                 irq_src_i[ctrl_reg[LTM_CTL_SRC_LSB +: 5]];
	assign capt_hit = clk_en_i && ctrl_reg[LTM_CTL_CAPT_EN] && !wide &&
	                  sel_src && !src_prev_reg;

	// Wait state: one per request, answer on the next edge
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if (clk_en_i) begin
			if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
				avs_waitrequest_o <= 1'b0;
			end else begin
				avs_waitrequest_o <= 1'b1;
			end
		end
	end

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		case (avs_address_i)
			LTM_ADDR_LOAD: rdata_next = {16'h0000, load_reg};
			LTM_ADDR_LOW:  rdata_next = {16'h0000, cnt_reg[15:0]};
			LTM_ADDR_HIGH: rdata_next = cnt_reg[47:16];
			LTM_ADDR_CTRL: rdata_next = ctrl_reg;
			LTM_ADDR_CAPT: rdata_next = {16'h0000, capt_reg};
			default:       rdata_next = 32'h00000000;
		endcase
	end

	// Read data latched as the wait state drops
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (clk_en_i) begin
			if (avs_read_i && avs_waitrequest_o) begin
				avs_readdata_o <= rdata_next;
			end
		end
	end

	// Control register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= LTM_CTRL_RST;
		end else if (wr_acc && avs_address_i == LTM_ADDR_CTRL) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Load register, lower two byte lanes
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			load_reg <= LTM_LOAD_RST;
		end else if (wr_acc && avs_address_i == LTM_ADDR_LOAD) begin
			load_reg <= (load_reg & ~wmask[15:0]) |
			            (avs_writedata_i[15:0] & wmask[15:0]);
		end
	end

	// Prescaler; held at zero while stopped
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pre_reg <= 15'h0000;
		end else if (clk_en_i) begin
			if (!ctrl_reg[LTM_CTL_ENABLE]) begin
				pre_reg <= 15'h0000;
			end else if (src_tick) begin
				if (pre_reg >= pre_max) begin
					pre_reg <= 15'h0000;
				end else begin
					pre_reg <= pre_reg + 15'h0001;
				end
			end
		end
	end

	// Counter
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cnt_reg <= LTM_CNT_RST;
		end else if (wr_acc && avs_address_i == LTM_ADDR_CTRL &&
		             ctrl_next[LTM_CTL_WIDE] != wide) begin
			// Mode change restarts from zero
			cnt_reg <= LTM_CNT_RST;
		end else if (wr_acc && avs_address_i == LTM_ADDR_LOAD && !wide) begin
			// Load write also presets the 16-bit count
			cnt_reg <= {32'h00000000, avs_writedata_i[15:0]};
		end else if (cnt_tick) begin
			if (wide) begin
				cnt_reg <= cnt_reg + 48'h000000000001;
			end else if (wrap && ctrl_reg[LTM_CTL_PERIODIC]) begin
				cnt_reg <= {32'h00000000, load_reg};
			end else if (up) begin
				cnt_reg <= {32'h00000000, cnt_reg[15:0] + 16'h0001};
			end else begin
				cnt_reg <= {32'h00000000, cnt_reg[15:0] - 16'h0001};
			end
		end
	end

	// Source history for first-assertion detect
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			src_prev_reg <= 1'b0;
		end else if (clk_en_i) begin
			src_prev_reg <= sel_src;
		end
	end

	// Capture register; counter keeps running
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			capt_reg <= LTM_CAPT_RST;
		end else if (capt_hit) begin
			capt_reg <= cnt_reg[15:0];
		end
	end

	// Pending interrupt; a wrap in the clear cycle wins
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else if (wrap) begin
			irq_o <= 1'b1;
		end else if (clr_hit && !wide) begin
			irq_o <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Accepted request and its one-cycle answer
	sequence s_req;
		clk_en_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence

	// Selected source rising while capture armed in 16-bit mode
	sequence s_capt;
		capt_hit ##1 1'b1;
	endsequence

	AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest_o
		##1 (!$past(clk_en_i) || avs_waitrequest_o))
		else $error("waitrequest not a single-cycle drop");

	AST_STOPPED: assert property (clk_en_i && !ctrl_reg[LTM_CTL_ENABLE]
		&& !wr_acc |=> $stable(cnt_reg))
		else $error("counter moved while stopped");

	AST_WIDE_UP: assert property (cnt_tick && wide && !wr_acc
		|=> cnt_reg == $past(cnt_reg) + 48'h000000000001)
		else $error("wide mode did not step up by one");

	AST_DOWN: assert property (cnt_tick && !wide && !up && !wr_acc
		&& cnt_reg[15:0] != LTM_N_MIN
		|=> cnt_reg[15:0] == $past(cnt_reg[15:0]) - 16'h0001)
		else $error("16-bit down count wrong");

	AST_RELOAD: assert property (wrap && ctrl_reg[LTM_CTL_PERIODIC]
		&& !wr_acc |=> cnt_reg[15:0] == $past(load_reg))
		else $error("periodic wrap did not reload");

	AST_FREE_WRAP: assert property (wrap && up && !ctrl_reg[LTM_CTL_PERIODIC]
		&& !wr_acc |=> cnt_reg[15:0] == LTM_N_MIN)
		else $error("free-running overflow did not wrap to zero");

	AST_IRQ_SET: assert property (wrap |=> irq_o ##1 irq_o
		|| $past(clr_hit))
		else $error("wrap did not raise interrupt");

	AST_IRQ_CLR: assert property (clr_hit && !wide && !wrap |=> !irq_o)
		else $error("clear write did not drop interrupt");

	AST_CAPT: assert property (s_capt |-> capt_reg ==
		$past(cnt_reg[15:0]))
		else $error("capture missed the count");

	AST_NO_CAPT_WIDE: assert property (wide |=> $stable(capt_reg))
		else $error("capture changed in wide mode");

	AST_RESERVED: assert property ((ctrl_reg & ~LTM_CTRL_MASK) == 32'h0)
		else $error("reserved control bits set");

	AST_CORE_CLK: assert property (clk_en_i && ctrl_reg[LTM_CTL_ENABLE]
		&& ctrl_reg[LTM_CTL_CLK_LSB +: 2] == LTM_CLK_CORE
		&& ctrl_reg[LTM_CTL_PRE_LSB +: 4] == LTM_PRE_DIV1 |-> cnt_tick)
		else $error("core clock divide-by-one did not step");

endmodule

// [verilog/ltm_pkg.sv]
/*
 * Constants of the lifetime timer: register byte addresses, control
 * field positions, reset values and prescaler divide counts.
 * Assumes a 32-bit Avalon-MM slave port that decodes full byte addresses.
 */
package ltm_pkg;

	// Register byte addresses
	localparam logic [31:0] LTM_ADDR_LOAD  = 32'hFFFF0300;
	localparam logic [31:0] LTM_ADDR_LOW   = 32'hFFFF0304;
	localparam logic [31:0] LTM_ADDR_HIGH  = 32'hFFFF0308;
	localparam logic [31:0] LTM_ADDR_CTRL  = 32'hFFFF030C;
	localparam logic [31:0] LTM_ADDR_CLEAR = 32'hFFFF0310;
	localparam logic [31:0] LTM_ADDR_CAPT  = 32'hFFFF0314;

	// Control field positions
	localparam int LTM_CTL_PRE_LSB  = 0;
	localparam int LTM_CTL_WIDE     = 4;
	localparam int LTM_CTL_PERIODIC = 6;
	localparam int LTM_CTL_ENABLE   = 7;
	localparam int LTM_CTL_UP       = 8;
	localparam int LTM_CTL_CLK_LSB  = 9;
	localparam int LTM_CTL_SRC_LSB  = 12;
	localparam int LTM_CTL_CAPT_EN  = 17;

	// Implemented control bits; the rest read back as zero
	localparam logic [31:0] LTM_CTRL_MASK = 32'h0003F7DF;

	// Reset values
	localparam logic [31:0] LTM_CTRL_RST = 32'h00000000;
	localparam logic [15:0] LTM_LOAD_RST = 16'h0000;
	localparam logic [15:0] LTM_CAPT_RST = 16'h0000;
	localparam logic [47:0] LTM_CNT_RST  = 48'h000000000000;

	// Clock source codes
	localparam logic [1:0] LTM_CLK_CORE = 2'h0;
	localparam logic [1:0] LTM_CLK_LPO  = 2'h1;
	localparam logic [1:0] LTM_CLK_XTAL = 2'h2;
	localparam logic [1:0] LTM_CLK_PREC = 2'h3;

	// Prescaler codes and their terminal counts (ratio minus one)
	localparam logic [3:0]  LTM_PRE_DIV1     = 4'h0;
	localparam logic [3:0]  LTM_PRE_DIV16    = 4'h4;
	localparam logic [3:0]  LTM_PRE_DIV256   = 4'h8;
	localparam logic [3:0]  LTM_PRE_DIV32768 = 4'hF;
	localparam logic [14:0] LTM_PRE_MAX1     = 15'h0000;
	localparam logic [14:0] LTM_PRE_MAX16    = 15'h000F;
	localparam logic [14:0] LTM_PRE_MAX256   = 15'h00FF;
	localparam logic [14:0] LTM_PRE_MAX32768 = 15'h7FFF;

	// Interrupt source count feeding capture
	localparam int          LTM_NUM_SRC = 18;
	localparam logic [4:0]  LTM_SRC_LAST = 5'h11;
	localparam logic [15:0] LTM_N_MAX    = 16'hFFFF;
	localparam logic [15:0] LTM_N_MIN    = 16'h0000;

endpackage

// [verilog/ltm_edge_sync.sv]
/*
 * Three-flop synchroniser with agreement filter for one slow clock pin.
 * Assumes the pin toggles far slower than sys_clk_i; emits one-cycle
 * pulse on each agreed rising edge.
 */
`timescale 1ns/1ps
module ltm_edge_sync
	import ltm_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic clk_en_i,
	input  wire logic pin_i,
	output logic      rise_o
);

	logic s1_reg;   // First stage, read only by second
	logic s2_reg;   // Second stage
	logic s3_reg;   // Third stage
	logic lvl_reg;  // Agreed level

	// Shift chain
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else if (clk_en_i) begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Level and edge only once stages two and three agree
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			lvl_reg <= 1'b0;
			rise_o  <= 1'b0;
		end else if (clk_en_i) begin
			if (s2_reg == s3_reg) begin
				lvl_reg <= s3_reg;
			end
			rise_o <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
		end
	end

endmodule

// [tb/ltm_timer_tb.sv]
/*
 * Self-checking bench for the lifetime timer through its Avalon-MM port.
 * Assumes ltm_pkg and ltm_timer are compiled first; the bench drives
 * every pin itself and there is no partner model.
 */
`timescale 1ns/1ps
module lifetime_timer_with_capture_tb_top
	import ltm_pkg::*;
;
	logic        sys_clk_i;       // 200 MHz system clock
	logic        sys_rst_i;       // Synchronous reset
	logic        avs_read_i;      // Bus read strobe
	logic        avs_write_i;     // Bus write strobe
	logic [31:0] avs_address_i;   // Bus byte address
	logic [31:0] avs_writedata_i; // Bus write data
	logic [31:0] avs_readdata_o;  // Bus read data
	logic        avs_waitrequest_o; // Bus stall
	logic [2:0]  osc;             // Slow clock pins
	logic [17:0] irq_src_i;       // Capture trigger sources
	logic        irq_o;           // Pending interrupt
	logic        clk_en_i;        // Clock enable
	int          err_count;       // Mismatches seen
	int          cmp_count;       // Comparisons made

	// Device under test
	ltm_timer i_dut (
		.sys_clk_i         (sys_clk_i),
		.sys_rst_i         (sys_rst_i),
		.clk_en_i          (clk_en_i),
		.avs_address_i     (avs_address_i),
		.avs_read_i        (avs_read_i),
		.avs_write_i       (avs_write_i),
		.avs_writedata_i   (avs_writedata_i),
		.avs_byteenable_i  (4'hF),
		.avs_readdata_o    (avs_readdata_o),
		.avs_waitrequest_o (avs_waitrequest_o),
		.lp_osc_i          (osc[0]),
		.xtal_i            (osc[1]),
		.prec_osc_i        (osc[2]),
		.irq_src_i         (irq_src_i),
		.irq_o             (irq_o)
	);

	// Clock generator
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// Verdict and end of run
	task automatic print_verdict();
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input string nm, input logic [47:0] seen,
		input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk_i);
		avs_address_i   <= a;
		avs_writedata_i <= d;
		if (wr) avs_write_i <= 1'b1;
		else avs_read_i <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
		if (avs_waitrequest_o !== 1'b0) begin
			err_count++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h00000000, q);
	endtask

	// Pulse one capture source for two cycles
	task automatic pulse(input int i);
		@(posedge sys_clk_i);
		irq_src_i[i] <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		irq_src_i[i] <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask

	// Bounded wait for the interrupt
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 200) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk("irq_raised", irq_o, 1);
	endtask

	// Reset values, unmapped place and reserved control bits
	task automatic t_reset();
		logic [31:0] q;
		rd(LTM_ADDR_LOAD, q);  chk("load_rst", q, LTM_LOAD_RST);
		rd(LTM_ADDR_LOW, q);   chk("low_rst", q, 0);
		rd(LTM_ADDR_HIGH, q);  chk("high_rst", q, 0);
		rd(LTM_ADDR_CTRL, q);  chk("ctrl_rst", q, LTM_CTRL_RST);
		rd(LTM_ADDR_CAPT, q);  chk("capt_rst", q, LTM_CAPT_RST);
		rd(LTM_ADDR_CLEAR, q); chk("clear_rd", q, 0);
		rd(32'hFFFF0318, q);   chk("unmapped", q, 0);
		chk("irq_rst", irq_o, 0);
		wr(LTM_ADDR_CTRL, 32'hFFFC0820);
		rd(LTM_ADDR_CTRL, q);  chk("ctrl_resv", q, 0);
		rd(LTM_ADDR_LOW, q);   chk("low_resv", q, 0);
	endtask

	// Capture on selected source only, counter stopped and undisturbed
	task automatic t_capture();
		logic [31:0] q;
		wr(LTM_ADDR_LOAD, 32'h00001234);
		rd(LTM_ADDR_LOW, q);  chk("low_load", q, 32'h1234);
		wr(LTM_ADDR_CTRL, 32'h00025000);
		pulse(5);
		rd(LTM_ADDR_CAPT, q); chk("capt_sel", q, 32'h1234);
		rd(LTM_ADDR_LOW, q);  chk("low_stop", q, 32'h1234);
		wr(LTM_ADDR_LOAD, 32'h00000042);
		pulse(6);
		rd(LTM_ADDR_CAPT, q); chk("capt_other", q, 32'h1234);
		wr(LTM_ADDR_CTRL, 32'h00005000);
		pulse(5);
		rd(LTM_ADDR_CAPT, q); chk("capt_off", q, 32'h1234);
		wr(LTM_ADDR_CTRL, 32'h00031000);
		pulse(17);
		rd(LTM_ADDR_CAPT, q); chk("capt_last", q, 32'h0042);
	endtask

	// Periodic reload, interrupt hold and clear, free-running wrap
	task automatic t_modes();
		logic [31:0] q;
		wr(LTM_ADDR_CTRL, 32'h00000000);
		wr(LTM_ADDR_LOAD, 32'h00000005);
		wr(LTM_ADDR_CTRL, 32'h000000C0);
		wait_irq();
		repeat (3) begin
			rd(LTM_ADDR_LOW, q);
			chk("reload_range", q <= 32'h5, 1);
		end
		wr(LTM_ADDR_CTRL, 32'h00000040);
		repeat (4) @(posedge sys_clk_i);
		chk("irq_held", irq_o, 1);
		wr(LTM_ADDR_CLEAR, 32'h000000A5);
		repeat (2) @(posedge sys_clk_i);
		chk("irq_cleared", irq_o, 0);
		wr(LTM_ADDR_LOAD, 32'h00000002);
		wr(LTM_ADDR_CTRL, 32'h00000080);
		wait_irq();
		wr(LTM_ADDR_CTRL, 32'h00000000);
		rd(LTM_ADDR_LOW, q);  chk("free_wrap", q[15:8], 8'hFF);
		wr(LTM_ADDR_CLEAR, 32'h00000000);
		// Up count overflow wraps to zero when free-running
		wr(LTM_ADDR_LOAD, 32'h0000FFFD);
		wr(LTM_ADDR_CTRL, 32'h00000180);
		wait_irq();
		wr(LTM_ADDR_CTRL, 32'h00000000);
		rd(LTM_ADDR_LOW, q);  chk("up_wrap", q < 32'h10, 1);
		wr(LTM_ADDR_CLEAR, 32'h00000000);
	endtask

	// Wide mode counts up from zero; capture has no effect there
	task automatic t_wide();
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] h;
		wr(LTM_ADDR_LOAD, 32'h00000700);
		wr(LTM_ADDR_CTRL, 32'h000000D0);
		rd(LTM_ADDR_LOW, a);
		rd(LTM_ADDR_HIGH, h);
		rd(LTM_ADDR_LOW, b);
		chk("wide_start", a < 32'h10, 1);
		chk("wide_up", b > a, 1);
		chk("wide_high", h, 0);
		wr(LTM_ADDR_CTRL, 32'h000250D0);
		pulse(5);
		rd(LTM_ADDR_CAPT, a); chk("wide_capt", a, 32'h0042);
		wr(LTM_ADDR_CTRL, 32'h00000000);
	endtask

	// Prescaler ratios measured over a fixed span of core cycles
	task automatic t_prescale();
		logic [3:0] code[4] = '{4'h0, 4'h4, 4'h8, 4'hF};
		int         dv[4]   = '{1, 16, 256, 32768};
		logic [31:0] a;
		logic [31:0] b;
		int          e;
		for (int i = 0; i < 4; i++) begin
			wr(LTM_ADDR_LOAD, 32'h00000000);
			wr(LTM_ADDR_CTRL, 32'h00000180 | code[i]);
			rd(LTM_ADDR_LOW, a);
			repeat (5120) @(posedge sys_clk_i);
			rd(LTM_ADDR_LOW, b);
			wr(LTM_ADDR_CTRL, 32'h00000000);
			e = 5120 / dv[i];
			chk("prescale", (int'(b - a) >= e - 1) &&
				(int'(b - a) <= e + 4), 1);
		end
	endtask

	// Each slow source steps the counter once per pin rising edge
	task automatic t_source();
		logic [31:0] q;
		for (int s = 1; s < 4; s++) begin
			wr(LTM_ADDR_LOAD, 32'h00000000);
			wr(LTM_ADDR_CTRL, 32'h00000180 | (s << 9));
			repeat (8) begin
				osc[s-1] <= 1'b1;
				repeat (10) @(posedge sys_clk_i);
				osc[s-1] <= 1'b0;
				repeat (10) @(posedge sys_clk_i);
			end
			repeat (10) @(posedge sys_clk_i);
			rd(LTM_ADDR_LOW, q); chk("src_steps", q, 32'h8);
			wr(LTM_ADDR_CTRL, 32'h00000000);
		end
	endtask

	// Clock enable low freezes the running counter for 20 edges
	task automatic t_clken();
		logic [31:0] a;
		logic [31:0] b;
		wr(LTM_ADDR_LOAD, 32'h00000000);
		wr(LTM_ADDR_CTRL, 32'h00000180);
		rd(LTM_ADDR_LOW, a);
		clk_en_i <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		rd(LTM_ADDR_LOW, b);
		wr(LTM_ADDR_CTRL, 32'h00000000);
		chk("clken_hold", b - a, 32'h00000003);
	endtask

	// Main sequence
	initial begin
		err_count = 0;
		cmp_count = 0;
		sys_rst_i = 1'b1;
		clk_en_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 32'h00000000;
		avs_writedata_i = 32'h00000000;
		osc = 3'h0;
		irq_src_i = 18'h00000;
		repeat (10) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_capture();
		t_modes();
		t_wide();
		t_prescale();
		t_source();
		t_clken();
		print_verdict();
	end
endmodule
